// [tccu_pkg.sv]
// tccu_pkg: shared constants and types of the timer capture/compare unit
// assumes: one 8-bit register port, one clock at twice the peripheral rate
package tccu_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int TCCU_AW    = 8;   // register address width
  localparam int TCCU_DW    = 8;   // register data width
  localparam int TCCU_TW    = 16;  // timer and channel width
  localparam int TCCU_NCH   = 6;   // compare channels
  localparam int TCCU_NCAP  = 4;   // channels that can also capture

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;  // run, clock rate, cascade, pulses
  localparam logic [7:0] ADDR_T2RL_L   = 8'h01;  // base timer reload, low byte
  localparam logic [7:0] ADDR_T2RL_H   = 8'h02;
  localparam logic [7:0] ADDR_CCTRL_L  = 8'h03;  // cc timer reload, low byte
  localparam logic [7:0] ADDR_CCTRL_H  = 8'h04;
  localparam logic [7:0] ADDR_TBSEL    = 8'h05;  // per channel time base select
  localparam logic [7:0] ADDR_COCON    = 8'h06;  // compare mode, concurrent, polarities
  localparam logic [7:0] ADDR_COLVL    = 8'h07;  // mode 1 levels for next match
  localparam logic [7:0] ADDR_CAPCFG   = 8'h08;  // [3:0] capture role, [7:4] capture mode
  localparam logic [7:0] ADDR_CAPEDGE  = 8'h09;  // two edge bits per capture channel
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0A;  // sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0B;
  localparam logic [7:0] ADDR_T2CNT_L  = 8'h0C;  // base timer count, read only
  localparam logic [7:0] ADDR_T2CNT_H  = 8'h0D;
  localparam logic [7:0] ADDR_CCTCNT_L = 8'h0E;  // cc timer count, read only
  localparam logic [7:0] ADDR_CCTCNT_H = 8'h0F;
  localparam logic [3:0] ADDR_CC_PAGE  = 4'h1;   // 0x10 + 2*ch (+1 for high byte)

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_T2RUN  = 0;
  localparam int CTRL_CCTRUN = 1;
  localparam int CTRL_CLK2X  = 2;
  localparam int CTRL_CASC   = 3;
  localparam int CTRL_SHDOVF = 4;
  localparam int CTRL_SHDREQ = 5;  // write one: copy the shadows of all compare-role channels now
  localparam int CTRL_FORCE  = 6;  // write one: force cc timer overflow
  localparam int COCON_MODE  = 0;
  localparam int COCON_CONC  = 1;
  localparam int COCON_POLA  = 2;
  localparam int COCON_POLB  = 3;
  localparam int IRQ_T2OVF   = 6;
  localparam int IRQ_CCTOVF  = 7;
  localparam int GROUP_B_LO  = 3;  // channels 3..5 form group b

  // ---------------------------------------------------------------
  // reset values and edge codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  TCCU_RST8  = 8'h00;
  localparam logic [15:0] TCCU_RST16 = 16'h0000;
  localparam logic [15:0] TCCU_TMAX  = 16'hFFFF;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_FALL  = 2'h2;
  localparam logic [1:0]  EDGE_BOTH  = 2'h3;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tccu_bus_t;

endpackage

// [tccu_top.sv]
// tccu_top: timer capture/compare unit with two 16-bit time bases
// assumes: mclk_i is twice the peripheral clock, inputs are synchronous,
// the register master follows the one-cycle strobe protocol
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module tccu_top (
  input  wire logic               mclk_i,      // unit clock, 200 MHz
  input  wire logic               reset_i,     // asynchronous, active high
  input  wire tccu_pkg::tccu_bus_t bus_i,       // register port request
  input  wire logic [3:0]         cap_pin_i,   // capture input pins
  output logic [7:0]              rd_data_o,   // read data, cycle after read
  output logic [5:0]              cmp_o,       // compare outputs
  output logic                    irq_o        // level interrupt
);
  import tccu_pkg::*;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire        wr_ctrl   = bus_i.wr && (bus_i.addr == ADDR_CTRL);
  wire        wr_t2rl_l = bus_i.wr && (bus_i.addr == ADDR_T2RL_L);
  wire        wr_t2rl_h = bus_i.wr && (bus_i.addr == ADDR_T2RL_H);
  wire        wr_ccrl_l = bus_i.wr && (bus_i.addr == ADDR_CCTRL_L);
  wire        wr_ccrl_h = bus_i.wr && (bus_i.addr == ADDR_CCTRL_H);
  wire        wr_tbsel  = bus_i.wr && (bus_i.addr == ADDR_TBSEL);
  wire        wr_cocon  = bus_i.wr && (bus_i.addr == ADDR_COCON);
  wire        wr_colvl  = bus_i.wr && (bus_i.addr == ADDR_COLVL);
  wire        wr_capcfg = bus_i.wr && (bus_i.addr == ADDR_CAPCFG);
  wire        wr_capedg = bus_i.wr && (bus_i.addr == ADDR_CAPEDGE);
  wire        wr_stat   = bus_i.wr && (bus_i.addr == ADDR_IRQ_STAT);
  wire        wr_mask   = bus_i.wr && (bus_i.addr == ADDR_IRQ_MASK);
  wire [2:0]  cc_idx    = bus_i.addr[3:1];           // channel of a cc access
  wire        cc_hit    = (bus_i.addr[7:4] == ADDR_CC_PAGE) && (cc_idx < 3'(TCCU_NCH));
  wire        cc_hi     = bus_i.addr[0];             // high byte of a channel

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [4:0]  ctrl_reg;      // run bits, double rate, cascade, shadow on overflow
  logic [15:0] t2_rl_reg;     // base timer reload value
  logic [15:0] cct_rl_reg;    // cc timer reload value
  logic [5:0]  tbsel_reg;     // one: channel uses the cc timer
  logic [3:0]  cocon_reg;     // mode, concurrent, pol a, pol b
  logic [5:0]  colvl_reg;     // levels driven at next match in mode 1
  logic [7:0]  capcfg_reg;    // capture role and capture mode per channel
  logic [7:0]  capedg_reg;    // edge choice per capture channel
  logic [7:0]  stat_reg;      // sticky events
  logic [7:0]  mask_reg;      // interrupt enables

  // plain configuration storage, one write each
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg   <= 5'h00;
      t2_rl_reg  <= TCCU_RST16;
      cct_rl_reg <= TCCU_RST16;
      tbsel_reg  <= 6'h00;
      cocon_reg  <= 4'h0;
      colvl_reg  <= 6'h00;
      capcfg_reg <= TCCU_RST8;
      capedg_reg <= TCCU_RST8;
      mask_reg   <= TCCU_RST8;
    end else begin
      if (wr_ctrl)   ctrl_reg         <= bus_i.wdata[4:0];
      if (wr_t2rl_l) t2_rl_reg[7:0]   <= bus_i.wdata;
      if (wr_t2rl_h) t2_rl_reg[15:8]  <= bus_i.wdata;
      if (wr_ccrl_l) cct_rl_reg[7:0]  <= bus_i.wdata;
      if (wr_ccrl_h) cct_rl_reg[15:8] <= bus_i.wdata;
      if (wr_tbsel)  tbsel_reg        <= bus_i.wdata[5:0];
      if (wr_cocon)  cocon_reg        <= bus_i.wdata[3:0];
      if (wr_colvl)  colvl_reg        <= bus_i.wdata[5:0];
      if (wr_capcfg) capcfg_reg       <= bus_i.wdata;
      if (wr_capedg) capedg_reg       <= bus_i.wdata;
      if (wr_mask)   mask_reg         <= bus_i.wdata;
    end
  end

  // ---------------------------------------------------------------
  // time bases
  // ---------------------------------------------------------------
  logic        phase_reg;     // divides the unit clock down to the peripheral rate
  logic [15:0] t2_reg;        // base timer count
  logic [15:0] cct_reg;       // cc timer count

  wire tick      = ctrl_reg[CTRL_CLK2X] | phase_reg;
  wire t2_step   = ctrl_reg[CTRL_T2RUN] & tick;
  wire t2_ovf    = t2_step & (t2_reg == TCCU_TMAX);
  wire [15:0] t2_nxt = t2_ovf ? t2_rl_reg : t2_reg + 16'h0001;
  wire cct_inc   = ctrl_reg[CTRL_CASC] ? t2_ovf : tick;
  // forced overflow behaves as a natural one
  wire cct_force = wr_ctrl & bus_i.wdata[CTRL_FORCE];
  wire cct_step  = (ctrl_reg[CTRL_CCTRUN] & cct_inc) | cct_force;
  wire cct_ovf   = cct_force | (ctrl_reg[CTRL_CCTRUN] & cct_inc & (cct_reg == TCCU_TMAX));
  wire [15:0] cct_nxt = cct_ovf ? cct_rl_reg : cct_reg + 16'h0001;
  wire shd_req   = wr_ctrl & bus_i.wdata[CTRL_SHDREQ];

  // counters step only on their own tick, or the cc timer on a forced overflow; the phase runs free
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_reg <= 1'b0;
      t2_reg    <= TCCU_RST16;
      cct_reg   <= TCCU_RST16;
    end else begin
      phase_reg <= ~phase_reg;
      if (t2_step)  t2_reg  <= t2_nxt;
      if (cct_step) cct_reg <= cct_nxt;
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  logic [15:0] cc_act_reg [TCCU_NCH];  // active compare or captured value
  logic [15:0] cc_shd_reg [TCCU_NCH];  // shadow compare value
  logic [3:0]  pin_prev_reg;           // last pin level, for edge detect
  logic [5:0]  ch_ev;                  // match or capture event per channel
  logic [5:0]  ch_match;               // own compare match per channel

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) pin_prev_reg <= 4'h0;
    else         pin_prev_reg <= cap_pin_i;
  end

  genvar g;
  for (g = 0; g < TCCU_NCH; g++) begin : g_ch
    wire        sel    = tbsel_reg[g];
    wire [15:0] tb     = sel ? cct_reg : t2_reg;
    wire [15:0] tb_nxt = sel ? cct_nxt : t2_nxt;
    wire        step   = sel ? cct_step : t2_step;
    wire        ovf    = sel ? cct_ovf : t2_ovf;
    // capture role exists only on the low four channels
    wire        cap_on = (g < TCCU_NCAP) ? capcfg_reg[g % TCCU_NCAP] : 1'b0;
    wire        cap_sw = capcfg_reg[TCCU_NCAP + (g % TCCU_NCAP)];
    wire [1:0]  edg    = capedg_reg[2*(g % TCCU_NCAP) +: 2];
    wire        pin    = cap_pin_i[g % TCCU_NCAP];
    wire        pprev  = pin_prev_reg[g % TCCU_NCAP];
    wire        rise   = pin & ~pprev;
    wire        fall   = ~pin & pprev;
    wire        wr_lo  = bus_i.wr & cc_hit & ~cc_hi & (cc_idx == 3'(g));
    wire        wr_hi  = bus_i.wr & cc_hit & cc_hi & (cc_idx == 3'(g));
    wire        cap_hw = ~cap_sw & (((edg == EDGE_RISE) & rise) | ((edg == EDGE_FALL) & fall) |
                                    ((edg == EDGE_BOTH) & (rise | fall)));
    wire        cap_ev = cap_on & (cap_sw ? wr_lo : cap_hw);
    // shadow copy on request or on overflow
    wire        xfer   = ~cap_on & (shd_req | (ctrl_reg[CTRL_SHDOVF] & ovf));
    wire [15:0] cc_eff = xfer ? cc_shd_reg[g] : cc_act_reg[g];
    // match as the count steps onto the value
    assign ch_match[g] = ~cap_on & step & ~ovf & (tb_nxt == cc_act_reg[g]);
    assign ch_ev[g]    = cap_on ? cap_ev : ch_match[g];

    // active value: capture wins the channel in capture role
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        cc_act_reg[g] <= TCCU_RST16;
        cc_shd_reg[g] <= TCCU_RST16;
      end else begin
        if (cap_ev)
          cc_act_reg[g] <= tb;
        else if (xfer)
          cc_act_reg[g] <= cc_shd_reg[g];
        if (~cap_on && wr_lo) cc_shd_reg[g][7:0]  <= bus_i.wdata;
        if (~cap_on && wr_hi) cc_shd_reg[g][15:8] <= bus_i.wdata;
      end
    end

    wire pol    = (g < GROUP_B_LO) ? cocon_reg[COCON_POLA] : cocon_reg[COCON_POLB];
    // with concurrent set, channel 0 match acts on all compare-role outputs
    wire hit    = ch_match[g] | (cocon_reg[COCON_CONC] & ch_match[0] & ~cap_on);
    // mode 1 level; mode 0 active level
    wire lvl    = cocon_reg[COCON_MODE] ? colvl_reg[g] : pol;
    // period start uses the freshly transferred value
    wire rst_lv = (tb_nxt == cc_eff) ? pol : ~pol;

    // compare output flop
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i)
        cmp_o[g] <= 1'b0;
      else if (cap_on)
        cmp_o[g] <= ~pol;
      else if (~cocon_reg[COCON_MODE] && ovf)
        cmp_o[g] <= rst_lv;
      else if (hit)
        cmp_o[g] <= lvl;
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  wire [7:0] ev       = {cct_ovf, t2_ovf, ch_ev};
  wire [7:0] stat_clr = wr_stat ? bus_i.wdata : TCCU_RST8;
  // a new event beats a clear in the same cycle
  wire [7:0] stat_next = (stat_reg & ~stat_clr) | ev;
  // a mask written this cycle already counts, so the level never lags the registers
  wire [7:0] mask_next = wr_mask ? bus_i.wdata : mask_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      stat_reg <= TCCU_RST8;
      irq_o    <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_o    <= |(stat_next & mask_next);
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [15:0] cc_rd   = cc_act_reg[cc_idx];
  wire [7:0]  rd_cc   = cc_hi ? cc_rd[15:8] : cc_rd[7:0];
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = TCCU_RST8;
    unique case (bus_i.addr)
      ADDR_CTRL:     rd_mux = {3'h0, ctrl_reg};
      ADDR_T2RL_L:   rd_mux = t2_rl_reg[7:0];
      ADDR_T2RL_H:   rd_mux = t2_rl_reg[15:8];
      ADDR_CCTRL_L:  rd_mux = cct_rl_reg[7:0];
      ADDR_CCTRL_H:  rd_mux = cct_rl_reg[15:8];
      ADDR_TBSEL:    rd_mux = {2'h0, tbsel_reg};
      ADDR_COCON:    rd_mux = {4'h0, cocon_reg};
      ADDR_COLVL:    rd_mux = {2'h0, colvl_reg};
      ADDR_CAPCFG:   rd_mux = capcfg_reg;
      ADDR_CAPEDGE:  rd_mux = capedg_reg;
      ADDR_IRQ_STAT: rd_mux = stat_reg;
      ADDR_IRQ_MASK: rd_mux = mask_reg;
      ADDR_T2CNT_L:  rd_mux = t2_reg[7:0];
      ADDR_T2CNT_H:  rd_mux = t2_reg[15:8];
      ADDR_CCTCNT_L: rd_mux = cct_reg[7:0];
      ADDR_CCTCNT_H: rd_mux = cct_reg[15:8];
      default:       rd_mux = cc_hit ? rd_cc : TCCU_RST8;  // unmapped reads zero
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) rd_data_o <= TCCU_RST8;
    else         rd_data_o <= bus_i.rd ? rd_mux : TCCU_RST8;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_force;
    wr_ctrl && bus_i.wdata[CTRL_FORCE];
  endsequence

  sequence s_half_rate;
    ctrl_reg[CTRL_T2RUN] && !ctrl_reg[CTRL_CLK2X] && !wr_ctrl && (t2_rl_reg != TCCU_TMAX);
  endsequence

  a_base_timer_wrap: assert property (
    t2_ovf |=> t2_reg == $past(t2_rl_reg)) else $error("base timer did not reload");

  a_half_rate_step: assert property (
    s_half_rate ##1 s_half_rate |=> t2_reg != $past(t2_reg, 2)) else $error("half rate step missed");

  a_cascade_hold: assert property (
    ctrl_reg[CTRL_CASC] && !t2_ovf && !cct_force |=> $stable(cct_reg)) else $error("cascaded timer moved");

  a_force_restart: assert property (
    s_force |=> cct_reg == $past(cct_rl_reg) && stat_reg[IRQ_CCTOVF]) else $error("forced overflow lost");

  a_shadow_request: assert property (
    shd_req && !capcfg_reg[0] |=> cc_act_reg[0] == $past(cc_shd_reg[0])) else $error("shadow copy missed");

  a_mode0_match: assert property (
    !cocon_reg[COCON_MODE] && ch_match[1] && !t2_ovf && !cct_ovf
      |=> cmp_o[1] == $past(cocon_reg[COCON_POLA])) else $error("mode 0 match level wrong");

  a_mode1_level: assert property (
    cocon_reg[COCON_MODE] && ch_match[4] |=> cmp_o[4] == $past(colvl_reg[4])) else $error("mode 1 level wrong");

  a_pin_capture: assert property (
    g_ch[2].cap_hw && capcfg_reg[2] |=> cc_act_reg[2] == $past(g_ch[2].tb)) else $error("pin capture lost");

  a_soft_capture: assert property (
    g_ch[0].wr_lo && capcfg_reg[0] && capcfg_reg[4] |=> cc_act_reg[0] == $past(g_ch[0].tb))
    else $error("soft capture lost");

  a_irq_level: assert property (
    |(stat_reg & mask_reg) |-> irq_o) else $error("interrupt not raised");

  // channel 0 in mode 0 while its base timer wraps
  sequence s_ch0_wrap;
    !cocon_reg[COCON_MODE] && t2_ovf && !tbsel_reg[0] && !capcfg_reg[0];
  endsequence

  // double rate steps on every edge
  a_fast_step: assert property (
    ctrl_reg[CTRL_T2RUN] && ctrl_reg[CTRL_CLK2X] && (t2_reg != TCCU_TMAX)
      |=> t2_reg == $past(t2_reg) + 16'h0001) else $error("double rate step missed");

  // channel 0 follows the base timer
  a_base_match: assert property (
    !tbsel_reg[0] && !capcfg_reg[0] && t2_step && !t2_ovf && (t2_nxt == cc_act_reg[0])
      |-> ch_match[0]) else $error("base timer match missed");

  // channel 5 follows the cc timer
  a_cc_match: assert property (
    tbsel_reg[5] && cct_step && !cct_ovf && (cct_nxt == cc_act_reg[5])
      |-> ch_match[5]) else $error("cc timer match missed");

  // capture role never matches, output parked inactive
  a_capture_quiet: assert property (
    capcfg_reg[1] |-> !ch_match[1] ##1 (cmp_o[1] == ~$past(cocon_reg[COCON_POLA])))
    else $error("capture channel drove its output");

  // wrap returns channel 0 to inactive
  a_wrap_inactive: assert property (
    s_ch0_wrap ##0 (t2_rl_reg != g_ch[0].cc_eff) |=> cmp_o[0] == ~$past(cocon_reg[COCON_POLA]))
    else $error("wrap did not clear output");

  // group b takes its own active level
  a_group_b: assert property (
    !cocon_reg[COCON_MODE] && ch_match[4] && !t2_ovf && !cct_ovf
      |=> cmp_o[4] == $past(cocon_reg[COCON_POLB])) else $error("group b level wrong");

  // value equal to reload gives full duty
  a_full_duty: assert property (
    !cocon_reg[COCON_MODE] && cct_ovf && tbsel_reg[5] && (cct_rl_reg == g_ch[5].cc_eff)
      |=> cmp_o[5] == $past(cocon_reg[COCON_POLB])) else $error("full duty lost at wrap");

  // channel 0 match also drives channel 5
  a_conc_drive: assert property (
    cocon_reg[COCON_MODE] && cocon_reg[COCON_CONC] && ch_match[0]
      |=> cmp_o[5] == $past(colvl_reg[5])) else $error("concurrent match not applied");

  // a software-mode channel ignores its pin
  a_soft_only: assert property (
    capcfg_reg[3] && capcfg_reg[7] && !g_ch[3].wr_lo |=> $stable(cc_act_reg[3]))
    else $error("software channel captured on pin");

  // wrap transfer serves the period after it
  a_wrap_shadow: assert property (
    s_ch0_wrap ##0 ctrl_reg[CTRL_SHDOVF] |=> cc_act_reg[0] == $past(cc_shd_reg[0]))
    else $error("wrap transfer missed");

  // status bit sticks even when cleared in the same cycle
  a_event_sticky: assert property (
    ch_ev[0] |=> stat_reg[0]) else $error("event lost against clear");

  // read data rest at zero outside the answer cycle
  a_read_idle: assert property (
    !bus_i.rd |=> rd_data_o == TCCU_RST8) else $error("read data outside answer cycle");

  // nothing pending and unmasked means no interrupt
  a_irq_quiet: assert property (
    !(|(stat_reg & mask_reg)) |-> !irq_o) else $error("interrupt without cause");

endmodule

// [tccu_pin_model.sv]
// tccu_pin_model: the signal lines outside the capture pins
// assumes: the unit samples the pins on rising mclk_i edges
`timescale 1ns/1ps
module tccu_pin_model (
  input  wire logic       mclk_i,    // unit clock
  output logic      [3:0] cap_pin_o  // capture pin levels
);
  // ------------------------------------------------------------
  // pin driving
  // ------------------------------------------------------------
  initial cap_pin_o = 4'h0;  // lines idle low
  // change a line just after an edge, then hold it until the next call
  task automatic set_pin(input int ch, input logic v);
    @(posedge mclk_i);
    cap_pin_o[ch] <= v;
  endtask
endmodule

// [tccu_top_tb.sv]
// tccu_top_tb: self-checking bench of the capture/compare unit
// assumes: tccu_pkg and tccu_top compiled first, pin model beside it
`timescale 1ns/1ps
module tccu_top_tb;
  import tccu_pkg::*;
  logic        mclk_i  = 1'b0;  // 200 MHz unit clock
  logic        reset_i = 1'b1;  // held at start
  tccu_bus_t   bus     = '0;    // register port request
  logic [3:0]  cap_pin;         // from pin model
  logic [7:0]  rd_data;         // read data
  logic [5:0]  cmp;             // compare outputs
  logic        irq;             // interrupt level
  logic [7:0]  ctrl    = 8'h00; // mirror of the control register
  logic [15:0] rb, rc, r1, cv, v;
  logic [7:0]  d;
  int          n_fail = 0, check_count = 0, cyc = 0, hi, lo, p;

  // ------------------------------------------------------------
  // clock, design, far side
  // ------------------------------------------------------------
  always #2.5 mclk_i = ~mclk_i;
  tccu_top DUT (.mclk_i(mclk_i), .reset_i(reset_i), .bus_i(bus), .cap_pin_i(cap_pin),
                .rd_data_o(rd_data), .cmp_o(cmp), .irq_o(irq));
  tccu_pin_model PIN (.mclk_i(mclk_i), .cap_pin_o(cap_pin));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk_i);
    bus.addr  <= a;
    bus.wdata <= x;
    bus.wr    <= 1'b1;
    @(posedge mclk_i);
    bus.wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk_i);
    bus.rd   <= 1'b0;
    #1 x = rd_data;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    reg_wr(a, x[7:0]);
    reg_wr(a + 8'h01, x[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] x);
    reg_rd(a, x[7:0]);
    reg_rd(a + 8'h01, x[15:8]);
  endtask
  function automatic logic [7:0] cca(input int ch);
    return {ADDR_CC_PAGE, 3'(ch), 1'b0};
  endfunction
  task automatic pulse(input int b);
    reg_wr(ADDR_CTRL, ctrl | 8'(1 << b));
  endtask
  task automatic set_ctrl(input logic [7:0] x);
    ctrl = x;
    reg_wr(ADDR_CTRL, ctrl);
  endtask
  task automatic set_cc(input int ch, input logic [15:0] x);
    wr16(cca(ch), x);
    pulse(CTRL_SHDREQ);
  endtask
  // cycles of one whole active phase and the inactive phase after it
  task automatic measure(input int ch, input logic act, output int h, output int l);
    int n;
    h = 0;
    l = 0;
    n = 0;
    while (cmp[ch] === act && n < 3000) begin tick(); n++; end
    while (cmp[ch] !== act && n < 3000) begin tick(); n++; end
    while (cmp[ch] === act && n < 3000) begin tick(); n++; h++; end
    while (cmp[ch] !== act && n < 3000) begin tick(); n++; l++; end
  endtask

  // a hang counts as a mismatch
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    p = $urandom(19);
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    reg_rd(8'hFF, d);
    chk(16'(d), 16'h0000);
    // base timer starts now; its first overflow is a full 16-bit count away
    rb = 16'hFFFF - 16'($urandom_range(12, 3));
    wr16(ADDR_T2RL_L, rb);
    set_ctrl(8'h05);
    reg_wr(ADDR_TBSEL, 8'h30);
    wr16(cca(4), 16'h1234);
    rd16(cca(4), v);
    chk(v, 16'h0000);
    pulse(CTRL_SHDREQ);
    rd16(cca(4), v);
    chk(v, 16'h1234);
    rc = 16'hFFFF - 16'($urandom_range(12, 3));
    wr16(ADDR_CCTRL_L, rc);
    set_ctrl(ctrl | 8'h10);
    wr16(cca(4), 16'h00AB);
    pulse(CTRL_FORCE);
    rd16(ADDR_CCTCNT_L, v);
    chk(v, rc);
    reg_rd(ADDR_IRQ_STAT, d);
    chk(16'(d), 16'h0080);
    rd16(cca(4), v);
    chk(v, 16'h00AB);
    reg_wr(ADDR_IRQ_STAT, 8'hFF);
    // pin edge capture, rise / fall / both, ch3 in software mode
    reg_wr(ADDR_TBSEL, 8'h3F);
    reg_wr(ADDR_CAPCFG, 8'h8F);
    reg_wr(ADDR_CAPEDGE, 8'h79);
    r1 = rc;
    for (int i = 0; i < 4; i++) PIN.set_pin(i, 1'b1);
    repeat (3) tick();
    reg_rd(ADDR_IRQ_STAT, d);
    chk(16'(d), 16'h0005);
    rc = 16'hFFFF - 16'($urandom_range(12, 3)) - 16'h0010;
    wr16(ADDR_CCTRL_L, rc);
    pulse(CTRL_FORCE);
    for (int i = 0; i < 4; i++) PIN.set_pin(i, 1'b0);
    repeat (3) tick();
    reg_rd(ADDR_IRQ_STAT, d);
    chk(16'(d), 16'h0087);
    rd16(cca(0), v);
    chk(v, r1);
    rd16(cca(1), v);
    chk(v, rc);
    rd16(cca(2), v);
    chk(v, rc);
    reg_wr(cca(3), 8'h00);
    rd16(cca(3), v);
    chk(v, rc);
    // sticky status, mask and clear drive the level output
    reg_wr(ADDR_IRQ_MASK, 8'h08);
    tick();
    chk(16'(irq), 16'h0001);
    reg_wr(ADDR_IRQ_STAT, 8'h08);
    tick();
    chk(16'(irq), 16'h0000);
    reg_rd(ADDR_IRQ_STAT, d);
    chk(16'(d), 16'h0087);
    reg_wr(ADDR_CAPCFG, 8'h00);
    // mode 0 on the cc timer, group b active low
    reg_wr(ADDR_COCON, 8'h04);
    set_ctrl(ctrl | 8'h02);
    cv = rc + 16'($urandom_range(int'(16'hFFFF - rc), 1));
    wr16(cca(5), rc);
    set_cc(4, cv);
    measure(4, 1'b0, hi, lo);
    chk(16'(hi), 16'(65536 - int'(cv)));
    chk(16'(lo), 16'(int'(cv) - int'(rc)));
    hi = 0;
    for (int i = 0; i < 40; i++) begin tick(); hi += (cmp[5] === 1'b0); end
    chk(16'(hi), 16'd40);
    set_cc(5, 16'h0000);
    repeat (30) tick();
    hi = 0;
    for (int i = 0; i < 40; i++) begin tick(); hi += (cmp[5] === 1'b0); end
    chk(16'(hi), 16'd0);
    // mode 1 with channel 0 acting on all, then on its own output only
    reg_wr(ADDR_COCON, 8'h03);
    wr16(cca(0), rc + 16'h0001);
    set_cc(1, 16'h0000);
    reg_wr(ADDR_COLVL, 8'h03);
    repeat (40) tick();
    chk(16'(cmp), 16'h0003);
    reg_wr(ADDR_COLVL, 8'h3C);
    repeat (40) tick();
    chk(16'(cmp), 16'h003C);
    reg_wr(ADDR_COCON, 8'h01);
    reg_wr(ADDR_COLVL, 8'h3F);
    repeat (40) tick();
    chk(16'(cmp), 16'h003D);
    // channel 0 on the base timer once it wraps
    reg_wr(ADDR_COCON, 8'h04);
    reg_wr(ADDR_TBSEL, 8'h3E);
    cv = rb + 16'($urandom_range(int'(16'hFFFF - rb), 1));
    set_cc(0, cv);
    while (cyc < 66500) tick();
    measure(0, 1'b1, hi, lo);
    chk(16'(hi), 16'(65536 - int'(cv)));
    chk(16'(lo), 16'(int'(cv) - int'(rb)));
    // cc timer steps once per base overflow
    wr16(ADDR_CCTRL_L, 16'hFFFE);
    set_ctrl(ctrl | 8'h08);
    set_cc(1, 16'hFFFF);
    pulse(CTRL_FORCE);
    measure(1, 1'b1, hi, lo);
    chk(16'(hi), 16'(65536 - int'(rb)));
    chk(16'(lo), 16'(65536 - int'(rb)));
    set_ctrl(ctrl & 8'hF3);
    measure(0, 1'b1, hi, lo);
    chk(16'(hi), 16'(2 * (65536 - int'(cv))));
    chk(16'(lo), 16'(2 * (int'(cv) - int'(rb))));
    tally_and_finish();
  end
endmodule
